// ===== sat_task_processor.sv
// Command interpreter and decode status logic of the subaudio tone task processor.
`timescale 1ns/10ps
module sat_task_processor
	import sat_pkg::*;
#(
	parameter int TICK_CYCLES    = TS_UNIT_CYCLES,
	parameter int NOTONE_DEFAULT = TS_NOTONE_UNITS,
	parameter int QUAL_COUNT     = TS_QUAL_COUNT,
	parameter int HYST_MISSES    = TS_HYST_MISSES
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic        meas_valid,
	input  wire logic        meas_present,
	input  wire logic [5:0]  meas_match,
	output logic             proc_enabled,
	output logic             irq_ctrl,
	output logic             encoding,
	output logic             decoding,
	output logic      [51:0] det_enable,
	output logic      [9:0]  user_rx_n,
	output logic      [5:0]  user_rx_r,
	output logic      [15:0] bw_trim,
	output logic      [15:0] notone_trim,
	output logic      [5:0]  tx_tone_index,
	output logic      [15:0] tx_user_tone,
	output logic      [15:0] ring_tone,
	output logic      [15:0] tx_timer,
	output logic      [7:0]  aux_cfg,
	output logic             decode_flag,
	output logic      [5:0]  decode_index
);

	// ************************************************************
	// Host side registers
	// ************************************************************
	logic        wr_ctrl;
	logic        wr_byte;
	logic        gen_reset;
	logic [7:0]  arg_byte_q;
	logic [15:0] arg_word_q;
	logic [7:0]  ctrl_q;
	logic        tx_sel_q;
	logic        task_go_q;
	logic [3:0]  task_q;
	logic [7:0]  task_byte_q;
	logic [15:0] task_word_q;
	sat_mode_t   mode_q;

	assign wr_ctrl   = reg_wr && (reg_addr == TS_ADDR_CTRL);
	assign wr_byte   = reg_wr && (reg_addr == TS_ADDR_BYTE);
	assign gen_reset = reg_wr && (reg_addr == TS_ADDR_RESET);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			arg_byte_q <= 8'h00;
			arg_word_q <= 16'h0000;
			tx_sel_q   <= 1'b0;
			ctrl_q     <= 8'h00;
		end else if (gen_reset) begin
			arg_byte_q <= 8'h00;
			arg_word_q <= 16'h0000;
			tx_sel_q   <= 1'b0;
			ctrl_q     <= 8'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				TS_ADDR_BYTE:  arg_byte_q <= reg_wdata[7:0];
				TS_ADDR_WORD:  arg_word_q <= reg_wdata;
				TS_ADDR_SETUP: tx_sel_q   <= reg_wdata[TS_SETUP_TX_BIT];
				TS_ADDR_CTRL:  ctrl_q     <= reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	// Control reads show the last control value, status reads the decoder state.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				TS_ADDR_CTRL:   reg_rdata <= {8'h00, ctrl_q};
				TS_ADDR_STATUS: reg_rdata <= {9'h000, decode_flag, decode_index};
				default:        reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ************************************************************
	// Task capture
	// ************************************************************
	// Arguments are copied at the control write, so a host that rewrites them
	// early cannot corrupt a task still waiting to run.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			task_go_q   <= 1'b0;
			task_q      <= TS_TASK_RUN;
			task_byte_q <= 8'h00;
			task_word_q <= 16'h0000;
		end else begin
			task_go_q <= wr_ctrl && reg_wdata[TS_CTRL_PWR_BIT] && !gen_reset;
			if (wr_ctrl) begin
				task_q      <= reg_wdata[TS_TASK_W-1:0];
				task_byte_q <= arg_byte_q;
				task_word_q <= arg_word_q;
			end
		end
	end

	function automatic logic [51:0] apply_det(input logic [51:0] mask, input logic [7:0] arg);
		logic [5:0] idx;
		logic       en;
		logic [51:0] res;
		idx = arg[TS_IDX_W-1:0];
		en  = arg[TS_ARG_EN_BIT];
		res = mask;
		if (idx == TS_IDX_ALL) begin
			res = en ? TS_ALL_MASK : 52'h0;
		end else if (idx == TS_IDX_STD) begin
			if (en) begin
				res = mask | TS_STD_MASK;
			end
		end else if ((idx != TS_IDX_NONE) && (idx <= TS_IDX_USER)) begin
			res[idx] = en;
		end
		return res;
	endfunction

	// ************************************************************
	// Mode and configuration
	// ************************************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= MODE_OFF;
		end else if (gen_reset || (wr_ctrl && !reg_wdata[TS_CTRL_PWR_BIT])) begin
			mode_q <= MODE_OFF;
		end else if (task_go_q) begin
			case (task_q)
				TS_TASK_RUN:      mode_q <= MODE_RUN;
				TS_TASK_FAST:     mode_q <= MODE_FAST;
				TS_TASK_MULTI:    mode_q <= MODE_MULTI;
				TS_TASK_SOFT_RST: mode_q <= MODE_CLEARED;
				default: begin
					if (mode_q == MODE_CLEARED || mode_q == MODE_MULTI || mode_q == MODE_OFF) begin
						mode_q <= MODE_FAST;
					end
				end
			endcase
		end
	end

	// A task strobe outranks a direct byte write in the same cycle; the host
	// spacing rules keep the two apart, so nothing is lost in normal use.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			det_enable <= 52'h0;
		end else if (gen_reset) begin
			det_enable <= 52'h0;
		end else if (task_go_q) begin
			case (task_q)
				TS_TASK_DET, TS_TASK_MULTI: det_enable <= apply_det(det_enable, task_byte_q);
				TS_TASK_SOFT_RST:           det_enable <= 52'h0;
				default: ;
			endcase
		end else if (wr_byte && mode_q == MODE_MULTI) begin
			det_enable <= apply_det(det_enable, reg_wdata[7:0]);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			user_rx_n     <= 10'h000;
			user_rx_r     <= 6'h00;
			bw_trim       <= 16'h0000;
			notone_trim   <= 16'h0000;
			tx_tone_index <= 6'h00;
			tx_user_tone  <= 16'h0000;
			ring_tone     <= 16'h0000;
			tx_timer      <= 16'h0000;
			aux_cfg       <= 8'h00;
		end else if (task_go_q) begin
			case (task_q)
				TS_TASK_USER_RX: begin
					user_rx_n <= task_word_q[15:TS_R_W];
					user_rx_r <= task_word_q[TS_R_W-1:0];
				end
				TS_TASK_BW:       bw_trim       <= task_word_q;
				TS_TASK_NOTONE:   notone_trim   <= task_word_q;
				TS_TASK_TX_PRE:   tx_tone_index <= task_byte_q[TS_IDX_W-1:0];
				TS_TASK_TX_USER:  tx_user_tone  <= task_word_q;
				TS_TASK_RING:     ring_tone     <= task_word_q;
				TS_TASK_TX_TIMER: tx_timer      <= task_word_q;
				TS_TASK_AUX:      aux_cfg       <= task_byte_q;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Run state outputs
	// ************************************************************
	logic dec_active;
	logic dec_active_q;

	// Status and timer start afresh whenever decoding is entered, so index 0 shows first.
	assign dec_active = (mode_q == MODE_RUN) && !tx_sel_q;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			proc_enabled <= 1'b0;
			irq_ctrl     <= 1'b0;
			encoding     <= 1'b0;
			decoding     <= 1'b0;
			dec_active_q <= 1'b0;
		end else begin
			proc_enabled <= (mode_q != MODE_OFF);
			irq_ctrl     <= ctrl_q[TS_CTRL_IRQ_BIT];
			encoding     <= (mode_q == MODE_RUN) && tx_sel_q;
			decoding     <= dec_active;
			dec_active_q <= dec_active;
		end
	end

	// ************************************************************
	// No-tone timer
	// ************************************************************
	// Counts in 60 us units from a shared divider so the long default fits in
	// a narrow counter; the expiry point is only accurate to one unit.
	logic [15:0]        tick_cnt_q;
	logic               tick;
	logic signed [17:0] limit_s;
	logic [15:0]        limit;
	logic [15:0]        notone_cnt_q;
	logic               seen_q;
	logic               expire;
	logic               restart;

	assign tick    = (tick_cnt_q == 16'(TICK_CYCLES - 1));
	assign limit_s = 18'(NOTONE_DEFAULT) + 18'($signed(notone_trim));
	assign limit   = (limit_s < 18'sd1) ? 16'h0001 :
		(limit_s > 18'sh0ffff) ? 16'hffff : limit_s[15:0];
	assign restart = dec_active && !dec_active_q;
	assign expire  = dec_active && seen_q && tick && (notone_cnt_q == limit - 16'h0001);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_q <= 16'h0000;
		end else if (tick) begin
			tick_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			notone_cnt_q <= 16'h0000;
			seen_q       <= 1'b0;
		end else if (restart || !dec_active) begin
			notone_cnt_q <= 16'h0000;
			seen_q       <= 1'b0;
		end else if (meas_valid && meas_present) begin
			notone_cnt_q <= 16'h0000;
			seen_q       <= 1'b1;
		end else if (tick && seen_q && notone_cnt_q < limit) begin
			notone_cnt_q <= notone_cnt_q + 16'h0001;
		end
	end

	// ************************************************************
	// Detector lookup
	// ************************************************************
	// The measured index reaches 63, past the last detector, so the mask is
	// widened with zeros rather than indexed out of range.
	logic [63:0] det_wide;

	assign det_wide = {12'h000, det_enable};

	// ************************************************************
	// Qualification and status
	// ************************************************************
	logic       match_ok;
	logic [5:0] cand_q;
	logic [3:0] qual_q;
	logic [3:0] miss_q;

	assign match_ok = meas_present && (meas_match != TS_IDX_NONE) &&
		(meas_match <= TS_IDX_USER) && det_wide[meas_match];

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			decode_flag  <= 1'b0;
			decode_index <= TS_IDX_NONE;
			cand_q       <= TS_IDX_NONE;
			qual_q       <= 4'h0;
			miss_q       <= 4'h0;
		end else if (restart || gen_reset) begin
			decode_flag  <= 1'b0;
			decode_index <= TS_IDX_NONE;
			cand_q       <= TS_IDX_NONE;
			qual_q       <= 4'h0;
			miss_q       <= 4'h0;
		end else if (dec_active && meas_valid) begin
			if (match_ok) begin
				miss_q       <= 4'h0;
				decode_index <= meas_match;
				if (meas_match == cand_q) begin
					if (qual_q >= 4'(QUAL_COUNT - 1)) begin
						decode_flag <= 1'b1;
					end else begin
						qual_q <= qual_q + 4'h1;
					end
				end else begin
					cand_q      <= meas_match;
					qual_q      <= 4'h1;
					decode_flag <= 1'b0;
				end
			end else if (decode_flag && miss_q < 4'(HYST_MISSES)) begin
				miss_q <= miss_q + 4'h1;
			end else begin
				decode_flag <= 1'b0;
				cand_q      <= TS_IDX_NONE;
				qual_q      <= 4'h0;
				miss_q      <= 4'h0;
				if (meas_present) begin
					decode_index <= TS_IDX_OTHER;
				end
			end
		end else if (expire) begin
			decode_flag  <= 1'b0;
			decode_index <= TS_IDX_NOTONE;
			cand_q       <= TS_IDX_NONE;
			qual_q       <= 4'h0;
			miss_q       <= 4'h0;
		end
	end

endmodule // sat_task_processor

// ===== sat_pkg.sv
// Constants, register map and types of the subaudio tone task processor.
//
// How it works
// - Fifty-one decoders, each enabled or disabled separately.
// - Status holds decode flag plus matching decoder index.
// - Flag clear, index 62: unmatched significant tone.
// - Flag clear, index 63: no-tone timer expired.
// - Index 0 until tone seen after enable/receive.
// - Unqualified enabled match shows its index, flag clear.
// - Detectors 1-50 preset, detector 51 host programmed.
// - Every enabling control write issues its task.
// - Task 0: encode on transmit, decode on receive.
// - Task 4: bit7 enable, bits5-0 detector index.
// - Index 63 all detectors, 62 enables standard set.
// - Task 5 programs detector 51 as N*64+R.
// - Task 6 shifts bandwidth by signed argument.
// - Small hysteresis keeps marginal detection from chattering.
// - Task 7 adjusts no-tone timer, 60 us units.
// - Tasks 8-15 select transmit, init, aux, soft reset.
// - Soft reset clears detectors; next task: fast init.
package sat_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] TS_ADDR_RESET  = 8'h01;
	localparam logic [7:0] TS_ADDR_SETUP  = 8'h80;
	localparam logic [7:0] TS_ADDR_WORD   = 8'h8e;
	localparam logic [7:0] TS_ADDR_CTRL   = 8'h93;
	localparam logic [7:0] TS_ADDR_STATUS = 8'h94;
	localparam logic [7:0] TS_ADDR_BYTE   = 8'h95;

	// ************************************************************
	// Field layouts
	// ************************************************************
	localparam int TS_SETUP_TX_BIT = 0;
	localparam int TS_CTRL_PWR_BIT = 6;
	localparam int TS_CTRL_IRQ_BIT = 5;
	localparam int TS_TASK_W       = 4;
	localparam int TS_ARG_EN_BIT   = 7;
	localparam int TS_IDX_W        = 6;
	localparam int TS_R_W          = 6;
	localparam int TS_STAT_FLAG    = 6;
	localparam int TS_NUM_DET      = 51;

	// ************************************************************
	// Task codes and special indices
	// ************************************************************
	localparam logic [3:0] TS_TASK_RUN      = 4'h0;
	localparam logic [3:0] TS_TASK_DET      = 4'h4;
	localparam logic [3:0] TS_TASK_USER_RX  = 4'h5;
	localparam logic [3:0] TS_TASK_BW       = 4'h6;
	localparam logic [3:0] TS_TASK_NOTONE   = 4'h7;
	localparam logic [3:0] TS_TASK_TX_PRE   = 4'h8;
	localparam logic [3:0] TS_TASK_TX_USER  = 4'h9;
	localparam logic [3:0] TS_TASK_RING     = 4'ha;
	localparam logic [3:0] TS_TASK_TX_TIMER = 4'hb;
	localparam logic [3:0] TS_TASK_FAST     = 4'hc;
	localparam logic [3:0] TS_TASK_MULTI    = 4'hd;
	localparam logic [3:0] TS_TASK_AUX      = 4'he;
	localparam logic [3:0] TS_TASK_SOFT_RST = 4'hf;

	localparam logic [5:0] TS_IDX_NONE   = 6'h00;
	localparam logic [5:0] TS_IDX_USER   = 6'h33;
	localparam logic [5:0] TS_IDX_STD    = 6'h3e;
	localparam logic [5:0] TS_IDX_ALL    = 6'h3f;
	localparam logic [5:0] TS_IDX_OTHER  = 6'h3e;
	localparam logic [5:0] TS_IDX_NOTONE = 6'h3f;

	// ************************************************************
	// Detector sets, bit n is detector n
	// ************************************************************
	localparam logic [51:0] TS_ALL_MASK    = 52'hf_ffff_ffff_fffe;
	localparam logic [51:0] TS_NONSTD_MASK = (52'h1 << 27) | (52'h1 << 29) | (52'h1 << 31) |
		(52'h1 << 33) | (52'h1 << 35) | (52'h1 << 37) | (52'h1 << 39) | (52'h1 << 40) |
		(52'h1 << 42) | (52'h1 << 46) | (52'h1 << 50) | (52'h1 << 51);
	localparam logic [51:0] TS_STD_MASK    = TS_ALL_MASK & ~TS_NONSTD_MASK;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int TS_CLK_HZ       = 125000000;
	localparam int TS_UNIT_US      = 60;
	localparam int TS_UNIT_CYCLES  = TS_UNIT_US * (TS_CLK_HZ / 1000000);
	localparam int TS_NOTONE_UNITS = 3000;
	localparam int TS_QUAL_COUNT   = 3;
	localparam int TS_HYST_MISSES  = 2;

	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_CLEARED,
		MODE_RUN,
		MODE_FAST,
		MODE_MULTI
	} sat_mode_t;

endpackage

// ===== sat_asserts.sv
// Port level assertions for the subaudio tone task processor.
`timescale 1ns/10ps
module sat_asserts
	import sat_pkg::*;
(
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        meas_valid,
	input wire logic        meas_present,
	input wire logic [5:0]  meas_match,
	input wire logic        irq_ctrl,
	input wire logic        encoding,
	input wire logic        decoding,
	input wire logic [51:0] det_enable,
	input wire logic        decode_flag,
	input wire logic [5:0]  decode_index
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic ctl_wr;
	logic ctl_on;
	assign ctl_wr = reg_wr && reg_addr == TS_ADDR_CTRL;
	assign ctl_on = ctl_wr && reg_wdata[TS_CTRL_PWR_BIT];
	AST_DET_ZERO: assert property (det_enable[0] == 1'b0)
		else $error("detector zero enabled");
	AST_FLAG_IDX: assert property (decode_flag |-> decode_index inside {[6'h01:6'h33]})
		else $error("decode flag with bad index");
	AST_RUN: assert property (ctl_on && reg_wdata[3:0] == TS_TASK_RUN |-> ##3 encoding ^ decoding)
		else $error("run task did not start encode or decode");
	AST_SOFT: assert property (ctl_on && reg_wdata[3:0] == TS_TASK_SOFT_RST |-> ##3 det_enable == '0)
		else $error("soft reset left detectors enabled");
	AST_IRQ: assert property (ctl_wr |-> ##3 irq_ctrl == $past(reg_wdata[TS_CTRL_IRQ_BIT], 3))
		else $error("interrupt control not taken from control write");
	AST_QUAL: assert property ($rose(decode_flag) |-> $past(meas_valid) && $stable(decode_index))
		else $error("flag set without prior unqualified report");
	AST_MATCH: assert property (decoding && meas_valid && meas_present && !decode_flag &&
		!(reg_wr && reg_addr == TS_ADDR_RESET) && meas_match <= TS_IDX_USER &&
		det_enable[meas_match] |=> !decoding || decode_index == $past(meas_match))
		else $error("enabled match index not reported");
	AST_ENTER: assert property ($rose(decoding) |-> decode_index == TS_IDX_NONE && !decode_flag)
		else $error("decode start did not report index zero");
endmodule // sat_asserts

bind sat_task_processor sat_asserts sat_asserts_i (.*);

// ===== sat_host.sv
// Host model that drives register writes and reads into the task processor.
`timescale 1ns/10ps
module sat_host
	import sat_pkg::*;
#(
	parameter int GAP = 4
) (
	input  wire logic        mclk,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [7:0]  reg_addr,
	output logic      [15:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
	endtask
	// Released lines show the inverse so a stale value never passes for a fresh one.
	task automatic idle();
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		reg_addr = a;
		idle();
	endtask
	// Task spacing is scaled far below the real interval to keep runs short.
	task automatic issue(input logic [7:0] a, input logic [15:0] d, input logic [3:0] t,
		input logic irq, input logic spoil);
		if (t inside {4'h1, 4'h2, 4'h3}) return;
		wr(a, d);
		wr(TS_ADDR_CTRL, {9'h000, 1'b1, irq, 1'b0, t});
		if (spoil) wr(a, ~d);
		idle();
		repeat (GAP) @(posedge mclk);
	endtask
endmodule // sat_host

// ===== subaudio_tone_task_processor_bench.sv
// Self-checking bench for the subaudio tone task processor.
`timescale 1ns/10ps
module subaudio_tone_task_processor_bench
	import sat_pkg::*;
;
	logic        mclk = 1'b0;
	logic        resetn, reg_wr, reg_rd, meas_valid, meas_present;
	logic        proc_enabled, irq_ctrl, encoding, decoding, decode_flag, rd_d, ok;
	logic [7:0]  reg_addr, aux_cfg, b;
	logic [15:0] reg_wdata, reg_rdata, bw_trim, notone_trim, tx_user_tone, ring_tone, tx_timer;
	logic [15:0] w, got;
	logic [5:0]  meas_match, user_rx_r, tx_tone_index, decode_index;
	logic [9:0]  user_rx_n;
	logic [51:0] det_enable;
	logic [15:0] exp_q[$];
	logic [31:0] lfsr = 32'h6ade;
	int          bad_count = 0;
	int          checks = 0;
	logic [3:0]  tl [7] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'he};
	logic [7:0]  a4 [6] = '{8'hbe, 8'h3f, 8'hbf, 8'h3f, 8'hc1, 8'hb3};
	logic [51:0] m4 [6] = '{TS_STD_MASK, 52'h0, TS_ALL_MASK, 52'h0, 52'h2, 52'h8_0000_0000_0002};

	sat_task_processor #(
		.TICK_CYCLES    (10),
		.NOTONE_DEFAULT (3)
	) sat_task_processor_i (.*);
	sat_host sat_host_i (.*);

	always #4 mclk = ~mclk;

	task automatic chk(input logic c, input string m);
		checks++;
		if (c !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic rdx(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		sat_host_i.rd(a);
	endtask
	task automatic meas(input logic [5:0] m);
		@(posedge mclk);
		#1;
		meas_valid = 1'b1;
		meas_present = 1'b1;
		meas_match = m;
		@(posedge mclk);
		#1;
		meas_valid = 1'b0;
		meas_present = 1'b0;
		meas_match = ~m;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Read data is taken one cycle after the strobe, oldest expectation first.
	always @(posedge mclk) begin
		if (rd_d === 1'b1) begin
			got = exp_q.pop_front();
			chk(reg_rdata === got, "read data");
		end
		rd_d <= reg_rd;
	end

	initial begin
		resetn = 1'b0;
		meas_valid = 1'b0;
		meas_present = 1'b0;
		meas_match = 6'h00;
		repeat (5) @(posedge mclk);
		#1;
		resetn = 1'b1;
		rdx(TS_ADDR_STATUS, 16'h0000);
		rdx(TS_ADDR_BYTE, 16'h0000);
		rdx(8'h42, 16'h0000);
		$display("test reset done");
		sat_host_i.issue(TS_ADDR_BYTE, 16'h0, TS_TASK_SOFT_RST, 1'b0, 1'b0);
		sat_host_i.issue(TS_ADDR_BYTE, 16'h0, TS_TASK_FAST, 1'b1, 1'b0);
		for (int i = 0; i < 6; i++) begin
			sat_host_i.issue(TS_ADDR_BYTE, {8'h00, a4[i]}, TS_TASK_DET, i[0], 1'b0);
			chk(det_enable === m4[i], "detector mask");
		end
		sat_host_i.issue(TS_ADDR_WORD, 16'h07ce, TS_TASK_USER_RX, 1'b0, 1'b1);
		chk(user_rx_n === 10'd31 && user_rx_r === 6'd14, "user detector");
		$display("test detectors done");
		foreach (tl[i]) begin
			lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
			w = lfsr[15:0];
			b = 8'(w % 16'd50) + 8'h01;
			sat_host_i.wr(TS_ADDR_WORD, w);
			if (tl[i] == TS_TASK_TX_PRE || tl[i] == TS_TASK_AUX) begin
				sat_host_i.issue(TS_ADDR_BYTE, {8'h00, b}, tl[i], 1'b1, 1'b1);
			end else begin
				sat_host_i.issue(TS_ADDR_WORD, w, tl[i], 1'b1, 1'b1);
			end
			case (tl[i])
				4'h6: ok = bw_trim === w;
				4'h7: ok = notone_trim === w;
				4'h8: ok = tx_tone_index === b[5:0];
				4'h9: ok = tx_user_tone === w;
				4'ha: ok = ring_tone === w;
				4'hb: ok = tx_timer === w;
				default: ok = aux_cfg === b;
			endcase
			chk(ok, "task argument");
		end
		sat_host_i.issue(TS_ADDR_WORD, 16'h0, TS_TASK_NOTONE, 1'b0, 1'b0);
		sat_host_i.issue(TS_ADDR_BYTE, 16'h3f, TS_TASK_MULTI, 1'b0, 1'b0);
		sat_host_i.wr(TS_ADDR_BYTE, 16'h0087);
		sat_host_i.idle();
		@(posedge mclk);
		chk(det_enable === 52'h80, "multi detector write");
		$display("test configuration done");
		sat_host_i.wr(TS_ADDR_SETUP, 16'h0000);
		sat_host_i.issue(TS_ADDR_BYTE, 16'h85, TS_TASK_DET, 1'b0, 1'b0);
		sat_host_i.issue(TS_ADDR_BYTE, 16'h0, TS_TASK_RUN, 1'b1, 1'b0);
		chk(decoding === 1'b1 && encoding === 1'b0, "receive run");
		rdx(TS_ADDR_STATUS, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			meas(i < 3 ? 6'd5 : 6'd9);
			rdx(TS_ADDR_STATUS, i == 5 ? 16'h003e : (i inside {0, 1} ? 16'h0005 : 16'h0045));
		end
		repeat (50) @(posedge mclk);
		rdx(TS_ADDR_STATUS, 16'h003f);
		$display("test decode done");
		sat_host_i.wr(TS_ADDR_SETUP, 16'h0001);
		sat_host_i.idle();
		repeat (3) @(posedge mclk);
		chk(encoding === 1'b1 && decoding === 1'b0, "transmit run");
		sat_host_i.wr(TS_ADDR_CTRL, 16'h0000);
		sat_host_i.idle();
		repeat (3) @(posedge mclk);
		chk(proc_enabled === 1'b0, "power off");
		sat_host_i.issue(TS_ADDR_BYTE, 16'h0, TS_TASK_SOFT_RST, 1'b0, 1'b0);
		chk(det_enable === 52'h0 && proc_enabled === 1'b1, "soft reset");
		$display("test modes done");
		repeat (4) @(posedge mclk);
		report_and_stop();
	end

	// The run needs well under ten thousand cycles, so this bound only trips on a hang.
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
endmodule // subaudio_tone_task_processor_bench
